// ==== common/slcr_pkg.sv ====
// Shared constants, register map and helper functions for the link control register bank.
package slcr_pkg;

    // Core clock rate and the startup interval step, in their own units.
    localparam int CLK_MHZ = 250;
    localparam int INIT_STEP_US = 100;
    // One step is an exact number of cycles, so no rounding is needed.
    localparam int INIT_STEP_CYC = INIT_STEP_US * CLK_MHZ;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_RXTERM = 8'h24;
    localparam logic [7:0] IDX_HDR_CTRL = 8'h31;
    localparam logic [7:0] IDX_BCC = 8'h32;
    localparam logic [7:0] IDX_DP = 8'h33;
    localparam logic [7:0] IDX_HDR_SHOW = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;

    // Values after reset.
    localparam logic [7:0] RST_RXTERM = 8'h00;
    localparam logic [7:0] RST_HDR_CTRL = 8'h20;
    localparam logic [7:0] RST_BCC = 8'h09;
    localparam logic [7:0] RST_DP = 8'h04;

    // Field positions.
    localparam int HDR_SEL_LSB = 6;
    localparam int HDR_FIXED_BIT = 5;
    localparam int HDR_PERCH_BIT = 4;
    localparam int BCC_ALL_BIT = 7;
    localparam int BCC_MATCH_BIT = 6;
    localparam int BCC_AACK_BIT = 5;
    localparam int BCC_PAR_BIT = 3;
    localparam int DP_CRC_BIT = 2;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_PERR_BIT = 1;

    // Control sequence framing and its check byte.
    localparam logic [2:0] SEQ_LAST_IDX = 3'h7;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Advances the check byte by one data byte, most significant bit first.
    function automatic logic [7:0] slcr_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : slcr_crc8

    // Lanes carried for each forward GPIO count code.
    function automatic logic [3:0] slcr_gpio_mask(input logic [1:0] code);
        case (code)
            2'h0: return 4'h0;
            2'h1: return 4'h1;
            2'h2: return 4'h3;
            default: return 4'hF;
        endcase
    endfunction : slcr_gpio_mask

endpackage : slcr_pkg

// ==== logic/slcr_hdr_mem.sv ====
// Small per-channel store of captured packet headers with a registered read port.
`timescale 1ns/100ps
module slcr_hdr_mem #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 64
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    // Storage holds no reset so it can map onto plain RAM cells.
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Write port.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Read data leaves through a register, one cycle after the address.
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule : slcr_hdr_mem

// ==== logic/slcr_init_timer.sv ====
// Startup interval timer: a step divider and a step counter.
`timescale 1ns/100ps
module slcr_init_timer #(
    parameter int STEP_CYCLES = slcr_pkg::INIT_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] code_i,
    output logic done_o
);
    import slcr_pkg::*;

    localparam int PW = $clog2(STEP_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYCLES - 1);

    logic [PW-1:0] pre_r; // Cycles within the current step.
    logic [3:0] step_r; // Whole steps elapsed.
    logic done_r; // Interval over.
    wire tick = (pre_r == PRE_LAST); // One-cycle step enable.
    wire [3:0] goal = {1'b0, code_i} + 4'h1; // Code 0 means one step.
    wire reach = tick && ((step_r + 4'h1) == goal);

    // Divider; it stops once the interval is over to save toggling.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_r <= '0;
        end else if (!done_r) begin
            pre_r <= tick ? '0 : pre_r + PW'(1);
        end
    end

    // Step count and the done flag; the code is read live while counting.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_r <= 4'h0;
            done_r <= 1'b0;
        end else if (!done_r && tick) begin
            step_r <= step_r + 4'h1;
            done_r <= reach || (step_r + 4'h1 >= goal);
        end
    end

    assign done_o = done_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // The flag rises only on a step edge that completes code plus one steps.
    init_step_a: assert property ($rose(done_r)
        |-> $past(tick) && $past(step_r) >= {1'b0, code_i})
        else $error("startup interval ended off a step boundary");
endmodule : slcr_init_timer

// ==== logic/slcr_link_regs.sv ====
// Link control register bank: bus slave, header display, I2C forwarding and forward framing.
`timescale 1ns/100ps

module slcr_link_regs #(
    parameter int ADDR_W = 12,
    parameter int STEP_CYCLES = slcr_pkg::INIT_STEP_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic hdr_valid_i,
    input wire logic hdr_interleaved_i,
    input wire logic [1:0] hdr_vc_i,
    input wire logic [31:0] hdr_raw_i,
    input wire logic [31:0] hdr_fixed_i,
    input wire logic [3:0] lp_ctrl_i,
    output logic [3:0] lp_ctrl_o,
    input wire logic i2c_req_i,
    input wire logic i2c_write_i,
    input wire logic i2c_addr_match_i,
    output logic i2c_fwd_o,
    output logic i2c_auto_ack_o,
    input wire logic bc_valid_i,
    input wire logic [7:0] bc_byte_i,
    input wire logic bc_parity_i,
    output logic bc_valid_o,
    output logic [7:0] bc_byte_o,
    output logic bc_parity_err_o,
    input wire logic seq_valid_i,
    input wire logic [7:0] seq_byte_i,
    output logic seq_ready_o,
    output logic seq_out_valid_o,
    output logic [7:0] seq_out_byte_o,
    output logic seq_out_crc_o,
    input wire logic [3:0] fwd_gpio_i,
    output logic [3:0] fwd_gpio_o,
    output logic [2:0] fwd_gpio_count_o,
    output logic [3:0] rx_term_o
);
    import slcr_pkg::*;

    // Reset release synchroniser; the first stage feeds only the second.
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Software registers; the four control registers are kept at full byte width so reserved bits read back.
    logic [7:0] rxterm_r; // Lane termination debug bits.
    logic [7:0] hdr_ctrl_r; // Header display and startup interval.
    logic [7:0] bcc_r; // Back channel and I2C forwarding.
    logic [7:0] dp_r; // Forward framing and GPIO count.
    logic perr_r; // Sticky back channel parity error.
    logic done_w; // Startup interval over.

    // Field views.
    wire [1:0] hdr_sel = hdr_ctrl_r[HDR_SEL_LSB +: 2];
    wire hdr_show_fixed = hdr_ctrl_r[HDR_FIXED_BIT];
    wire hdr_perch = hdr_ctrl_r[HDR_PERCH_BIT];
    wire [2:0] init_code = hdr_ctrl_r[2:0];
    wire fwd_all = bcc_r[BCC_ALL_BIT];
    wire fwd_match = bcc_r[BCC_MATCH_BIT];
    wire auto_ack = bcc_r[BCC_AACK_BIT];
    wire par_en = bcc_r[BCC_PAR_BIT];
    wire crc_en = dp_r[DP_CRC_BIT];
    wire [1:0] gpio_code = dp_r[1:0];

    // Write channel state: each half is held until the pair completes.
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic w_lane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire aw_take = s_axi_awvalid_i && awready_r;
    wire w_take = s_axi_wvalid_i && wready_r;
    wire do_wr = aw_held_r && w_held_r && !bvalid_r;
    wire b_done = bvalid_r && s_axi_bready_i;
    wire [7:0] wr_idx = aw_addr_r[9:2];
    wire wr_in_map = (aw_addr_r[ADDR_W-1:10] == '0);
    wire wr_known = wr_in_map && (wr_idx == IDX_RXTERM || wr_idx == IDX_HDR_CTRL
        || wr_idx == IDX_BCC || wr_idx == IDX_DP || wr_idx == IDX_HDR_SHOW
        || wr_idx == IDX_STATUS);
    wire wr_en = do_wr && wr_in_map && w_lane0_r;
    wire [7:0] wr_byte = w_data_r[7:0];

    // Write address and data are accepted in either order.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
        end else begin
            awready_r <= aw_take ? 1'b0 : (b_done ? 1'b1 : awready_r);
            wready_r <= w_take ? 1'b0 : (b_done ? 1'b1 : wready_r);
            aw_held_r <= aw_take ? 1'b1 : (do_wr ? 1'b0 : aw_held_r);
            w_held_r <= w_take ? 1'b1 : (do_wr ? 1'b0 : w_held_r);
        end
    end

    // Payload capture needs no reset; it is used only once held.
    always_ff @(posedge ref_clk_i) begin
        if (aw_take) begin
            aw_addr_r <= s_axi_awaddr_i;
        end
        if (w_take) begin
            w_data_r <= s_axi_wdata_i;
            w_lane0_r <= s_axi_wstrb_i[0];
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (b_done) begin
            bvalid_r <= 1'b0;
        end
    end

    // Register writes; only byte lane 0 carries data.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rxterm_r <= RST_RXTERM;
            hdr_ctrl_r <= RST_HDR_CTRL;
            bcc_r <= RST_BCC;
            dp_r <= RST_DP;
        end else if (wr_en) begin
            if (wr_idx == IDX_RXTERM) rxterm_r <= wr_byte;
            if (wr_idx == IDX_HDR_CTRL) hdr_ctrl_r <= wr_byte;
            if (wr_idx == IDX_BCC) bcc_r <= wr_byte;
            if (wr_idx == IDX_DP) dp_r <= wr_byte;
        end
    end

    // Header capture: with per-channel capture on, interleaved packets go to their channel slot, others to slot 0.
    wire [1:0] hdr_waddr = (hdr_perch && hdr_interleaved_i) ? hdr_vc_i : 2'h0;
    wire [1:0] hdr_raddr = hdr_perch ? hdr_sel : 2'h0;
    logic [63:0] hdr_q;
    slcr_hdr_mem #(.DEPTH(4), .WIDTH(64)) u_hdr_mem (
        .clk_i(ref_clk_i),
        .we_i(hdr_valid_i),
        .waddr_i(hdr_waddr),
        .wdata_i({hdr_fixed_i, hdr_raw_i}),
        .raddr_i(hdr_raddr),
        .rdata_o(hdr_q)
    );
    wire [31:0] hdr_show = hdr_show_fixed ? hdr_q[63:32] : hdr_q[31:0];

    // Read channel: one read at a time, answered on the edge after acceptance.
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire ar_take = s_axi_arvalid_i && arready_r;
    wire r_done = rvalid_r && s_axi_rready_i;
    wire [7:0] rd_idx = s_axi_araddr_i[9:2];
    wire rd_in_map = (s_axi_araddr_i[ADDR_W-1:10] == '0);
    wire [7:0] st_byte = {6'h00, perr_r, done_w};
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = rd_in_map;
        case (rd_idx)
            IDX_RXTERM: rd_mux = {24'h00_0000, rxterm_r};
            IDX_HDR_CTRL: rd_mux = {24'h00_0000, hdr_ctrl_r};
            IDX_BCC: rd_mux = {24'h00_0000, bcc_r};
            IDX_DP: rd_mux = {24'h00_0000, dp_r};
            IDX_HDR_SHOW: rd_mux = hdr_show;
            IDX_STATUS: rd_mux = {24'h00_0000, st_byte};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data are latched at acceptance and held until taken.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? rd_mux : 32'h0000_0000;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Startup interval during which lane low-power states are dropped.
    slcr_init_timer #(.STEP_CYCLES(STEP_CYCLES)) u_init (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .code_i(init_code),
        .done_o(done_w)
    );

    // Side decisions for I2C, back channel and GPIO, all same-clock inputs.
    wire i2c_fwd_nxt = i2c_req_i
        && (fwd_all || (fwd_match && i2c_addr_match_i));
    wire i2c_ack_nxt = i2c_req_i && i2c_write_i && auto_ack;
    wire bc_bad = ^{bc_byte_i, bc_parity_i};
    wire perr_nxt = bc_valid_i && par_en && bc_bad;
    wire perr_clr = wr_en && wr_idx == IDX_STATUS && wr_byte[ST_PERR_BIT];
    logic [3:0] lp_ctrl_r;
    logic i2c_fwd_r;
    logic i2c_ack_r;
    logic bc_valid_r;
    logic [7:0] bc_byte_r;
    logic bc_err_r;
    logic [3:0] gpio_r;
    logic [2:0] gpio_cnt_r;

    // Registered side outputs; a new parity error beats a clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lp_ctrl_r <= 4'h0;
            i2c_fwd_r <= 1'b0;
            i2c_ack_r <= 1'b0;
            bc_valid_r <= 1'b0;
            bc_byte_r <= 8'h00;
            bc_err_r <= 1'b0;
            perr_r <= 1'b0;
            gpio_r <= 4'h0;
            gpio_cnt_r <= 3'h0;
        end else begin
            lp_ctrl_r <= done_w ? lp_ctrl_i : 4'h0;
            i2c_fwd_r <= i2c_fwd_nxt;
            i2c_ack_r <= i2c_ack_nxt;
            bc_valid_r <= bc_valid_i;
            bc_byte_r <= bc_byte_i;
            bc_err_r <= perr_nxt;
            perr_r <= perr_nxt || (perr_r && !perr_clr);
            gpio_r <= fwd_gpio_i & slcr_gpio_mask(gpio_code);
            gpio_cnt_r <= (gpio_code == 2'h3) ? 3'h4 : {1'b0, gpio_code};
        end
    end

    // Control sequence framing: eight data bytes, then the check byte if enabled.
    logic [2:0] seq_cnt_r;
    logic [7:0] crc_r;
    logic crc_pend_r;
    logic seq_ready_r;
    logic seq_ov_r;
    logic [7:0] seq_ob_r;
    logic seq_oc_r;
    wire seq_take = seq_valid_i && seq_ready_r;
    wire seq_end = seq_take && seq_cnt_r == SEQ_LAST_IDX;
    wire [7:0] crc_nxt = slcr_crc8(crc_r, seq_byte_i);

    // The source is stalled for exactly one cycle, the one before the check byte leaves.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_cnt_r <= 3'h0;
            crc_r <= CRC_INIT;
            crc_pend_r <= 1'b0;
            seq_ready_r <= 1'b1;
            seq_ov_r <= 1'b0;
            seq_ob_r <= 8'h00;
            seq_oc_r <= 1'b0;
        end else if (crc_pend_r) begin
            crc_pend_r <= 1'b0;
            seq_ready_r <= 1'b1;
            seq_ov_r <= 1'b1;
            seq_ob_r <= crc_r;
            seq_oc_r <= 1'b1;
            crc_r <= CRC_INIT;
        end else begin
            seq_ov_r <= seq_take;
            seq_oc_r <= 1'b0;
            if (seq_take) begin
                seq_ob_r <= seq_byte_i;
                seq_cnt_r <= seq_cnt_r + 3'h1;
                crc_r <= (seq_end && !crc_en) ? CRC_INIT : crc_nxt;
                crc_pend_r <= seq_end && crc_en;
                seq_ready_r <= !(seq_end && crc_en);
            end
        end
    end

    // Outputs, each straight from a flip-flop.
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign lp_ctrl_o = lp_ctrl_r;
    assign i2c_fwd_o = i2c_fwd_r;
    assign i2c_auto_ack_o = i2c_ack_r;
    assign bc_valid_o = bc_valid_r;
    assign bc_byte_o = bc_byte_r;
    assign bc_parity_err_o = bc_err_r;
    assign seq_ready_o = seq_ready_r;
    assign seq_out_valid_o = seq_ov_r;
    assign seq_out_byte_o = seq_ob_r;
    assign seq_out_crc_o = seq_oc_r;
    assign fwd_gpio_o = gpio_r;
    assign fwd_gpio_count_o = gpio_cnt_r;
    assign rx_term_o = rxterm_r[3:0];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    // A last data byte with the check enabled is followed by the check byte.
    sequence last_byte_s;
        seq_take && seq_cnt_r == SEQ_LAST_IDX && crc_en;
    endsequence
    sequence crc_out_s;
        seq_out_crc_o && seq_out_valid_o && seq_ready_o;
    endsequence

    hdr_select_a: assert property (##1 $past(hdr_perch)
        |-> hdr_raddr == $past(hdr_sel) || $changed(hdr_ctrl_r))
        else $error("header read slot does not follow the channel selector");
    hdr_show_a: assert property (ar_take && rd_idx == IDX_HDR_SHOW && rd_in_map
        |=> s_axi_rdata_o == ($past(hdr_show_fixed) ? $past(hdr_q[63:32]) : $past(hdr_q[31:0])))
        else $error("header display picks the wrong copy");
    hdr_slot_a: assert property (hdr_valid_i && !(hdr_perch && hdr_interleaved_i)
        |-> hdr_waddr == 2'h0)
        else $error("plain header stored outside slot zero");
    lp_ignore_a: assert property (!done_w |=> lp_ctrl_o == 4'h0)
        else $error("low-power state passed during startup");
    fwd_all_a: assert property (i2c_req_i && fwd_all |=> i2c_fwd_o)
        else $error("pass-all did not forward");
    fwd_match_a: assert property (i2c_req_i && !fwd_all && fwd_match
        |=> i2c_fwd_o == $past(i2c_addr_match_i))
        else $error("matched forwarding ignores the decode");
    auto_ack_a: assert property (i2c_req_i && i2c_write_i
        |=> i2c_auto_ack_o == $past(auto_ack))
        else $error("auto acknowledge wrong");
    parity_off_a: assert property (bc_valid_i && !par_en |=> !bc_parity_err_o)
        else $error("parity error flagged while checking is off");
    // The source stalls for one cycle, then the flagged check byte leaves as ready returns.
    crc_ninth_a: assert property (last_byte_s |=> !seq_ready_o ##1 crc_out_s)
        else $error("check byte not sent ninth");
    // The count is derived from the lane mask rather than repeating the count decode.
    gpio_count_a: assert property (##1 fwd_gpio_count_o
        == 3'($countones(slcr_gpio_mask($past(gpio_code)))))
        else $error("forward GPIO count wrong");
    local_only_a: assert property (!fwd_all && !fwd_match |=> !i2c_fwd_o)
        else $error("I2C forwarded with both forwarding bits clear");
endmodule : slcr_link_regs

// ==== test/slcr_far_model.sv ====
// Far-side receiver model that collects the forward control sequence bytes.
`timescale 1ns/100ps
module slcr_far_model (
    input wire logic clk_i,
    input wire logic valid_i,
    input wire logic [7:0] byte_i,
    input wire logic crc_i,
    output int n_o,
    output int crc_pos_o,
    output logic crc_ok_o
);
    logic [7:0] acc; // Running check byte over the data bytes seen so far.
    // One CRC-8 step, poly 0x07, msb first; kept apart from the design's own code.
    function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        return c;
    endfunction : step
    initial begin
        acc = 8'h00;
        crc_ok_o = 1'b0;
    end
    // Counts every byte and judges the flagged one against the running check byte.
    always @(posedge clk_i) begin
        if (valid_i) begin
            n_o <= n_o + 1;
            if (crc_i) begin
                crc_pos_o <= n_o;
                crc_ok_o <= (byte_i === acc);
                acc <= 8'h00;
            end else begin
                acc <= step(acc, byte_i);
            end
        end
    end
endmodule : slcr_far_model

// ==== test/test_serializer_link_control_regs.sv ====
// Self-checking bench for the link control register bank.
`timescale 1ns/100ps
module test_serializer_link_control_regs;
    import slcr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wrd, bv, arr, rv;
    logic [31:0] wd = 0, rdat, hraw = 0, hfix = 0;
    logic [1:0] brsp, rrsp, hvc = 0;
    logic hv = 0, hil = 0, irq = 0, iwr = 1, imt = 0, bcv = 0, bcp = 0, sv = 0;
    logic [7:0] bcb = 0, sb = 0, sob, bbo;
    logic [3:0] lpi = 4'hF, gpi = 4'hF, lpo, gpo, rxt;
    logic [2:0] gcnt;
    logic fwd, ack, perr, srdy, sov, socrc, bvo;
    logic [31:0] d;
    logic [1:0] r;
    int num_errors = 0, n_checks = 0, cyc = 0, fn, fpos;
    logic fok;
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // A short step keeps the startup interval to at most 160 cycles.
    slcr_link_regs #(.ADDR_W(12), .STEP_CYCLES(20)) dut (.ref_clk_i(clk), .arst_n_i(rst_n),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(brsp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrsp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .hdr_valid_i(hv), .hdr_interleaved_i(hil), .hdr_vc_i(hvc), .hdr_raw_i(hraw),
        .hdr_fixed_i(hfix), .lp_ctrl_i(lpi), .lp_ctrl_o(lpo), .i2c_req_i(irq),
        .i2c_write_i(iwr), .i2c_addr_match_i(imt), .i2c_fwd_o(fwd), .i2c_auto_ack_o(ack),
        .bc_valid_i(bcv), .bc_byte_i(bcb), .bc_parity_i(bcp), .bc_valid_o(bvo), .bc_byte_o(bbo),
        .bc_parity_err_o(perr), .seq_valid_i(sv), .seq_byte_i(sb), .seq_ready_o(srdy),
        .seq_out_valid_o(sov), .seq_out_byte_o(sob), .seq_out_crc_o(socrc),
        .fwd_gpio_i(gpi), .fwd_gpio_o(gpo), .fwd_gpio_count_o(gcnt), .rx_term_o(rxt));
    slcr_far_model far (.clk_i(clk), .valid_i(sov), .byte_i(sob), .crc_i(socrc),
        .n_o(fn), .crc_pos_o(fpos), .crc_ok_o(fok));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // Bus write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
            if (bv) break;
        end
        r = brsp;
        bry <= 1'b0;
    endtask : wr
    // Bus read; rready stays high until the answer is sampled.
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdat;
        r = rrsp;
        rry <= 1'b0;
    endtask : rd
    // Reset, optionally set the startup code, then probe the lane gate early and late.
    task automatic t_start(input logic [2:0] c, input int lo, input int hi);
        int t;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t = cyc;
        // The block's own reset lifts two edges after release, so the first request waits.
        repeat (2) @(posedge clk);
        if (c != 0) wr(12'hC4, {5'h04, c});
        while (cyc < t + lo) @(posedge clk);
        chk(lpo, 4'h0);
        while (cyc < t + hi) @(posedge clk);
        chk(lpo, lpi);
    endtask : t_start
    task automatic hdr(input logic [1:0] vc, input logic il, input logic [31:0] a);
        @(posedge clk);
        hv <= 1'b1;
        hil <= il;
        hvc <= vc;
        hraw <= a;
        hfix <= ~a;
        @(posedge clk);
        hv <= 1'b0;
    endtask : hdr
    // The two bus-facing pulses answer one edge after the request is sampled.
    task automatic pulse(output logic f, output logic k, input bit isbc);
        @(posedge clk);
        if (isbc) bcv <= 1'b1;
        else irq <= 1'b1;
        @(posedge clk);
        bcv <= 1'b0;
        irq <= 1'b0;
        @(posedge clk);
        f = isbc ? perr : fwd;
        k = ack;
    endtask : pulse
    localparam logic [19:0] RST_LIST [4] = '{20'h09000, 20'h0C420, 20'h0C809, 20'h0CC04};
    initial begin
        logic f, k;
        int n;
        t_start(3'h0, 12, 30);
        foreach (RST_LIST[i]) begin
            rd(RST_LIST[i][19:8]);
            chk(d, {24'h0, RST_LIST[i][7:0]});
        end
        chk(rxt, 4'h0);
        rd(12'h3FC);
        chk(r, RESP_SLVERR);
        wr(12'h3FC, 8'hFF);
        chk(r, RESP_SLVERR);
        for (int i = 0; i < 16; i++) begin
            wr(12'hC8, {i[2:0], 5'h09});
            imt <= i[3];
            pulse(f, k, 1'b0);
            chk(f, i[2] | (i[1] & i[3]));
            chk(k, i[0]);
        end
        iwr <= 1'b0;
        pulse(f, k, 1'b0);
        chk(f, 1'b1);
        chk(k, 1'b0);
        bcb <= 8'h01;
        pulse(f, k, 1'b1);
        chk(f, 1'b1);
        chk({bvo, bbo}, 9'h101);
        rd(12'h104);
        chk(d, 32'h0000_0003);
        wr(12'h104, 8'h02);
        chk(r, RESP_OKAY);
        rd(12'h104);
        chk(d, 32'h0000_0001);
        wr(12'hC8, 8'h01);
        pulse(f, k, 1'b1);
        chk(f, 1'b0);
        for (int c = 0; c < 4; c++) begin
            wr(12'hCC, {6'h01, c[1:0]});
            @(posedge clk);
            chk(gcnt, (c == 3) ? 4 : c);
            chk(gpo, (4'h1 << ((c == 3) ? 4 : c)) - 1);
        end
        wr(12'hC4, 8'h20);
        hdr(2'h0, 1'b0, 32'h1234ABCD);
        rd(12'h100);
        chk(d, 32'hEDCB5432);
        wr(12'hC4, 8'h00);
        rd(12'h100);
        chk(d, 32'h1234ABCD);
        wr(12'hC4, 8'hB0);
        hdr(2'h2, 1'b1, 32'h0000C0DE);
        hdr(2'h1, 1'b1, 32'h0BAD0001);
        hdr(2'h2, 1'b0, 32'h0BAD0002);
        rd(12'h100);
        chk(d, 32'hFFFF3F21);
        wr(12'hC4, 8'hE0);
        rd(12'h100);
        chk(d, 32'hF452FFFD);
        @(posedge clk);
        sv <= 1'b1;
        sb <= 8'h01;
        n = 0;
        while (n < 8) begin
            @(posedge clk);
            if (srdy) begin
                n++;
                sb <= 8'(n * 37 + 1);
                if (n == 8) sv <= 1'b0;
            end
        end
        repeat (4) @(posedge clk);
        chk(fn, 9);
        chk(fpos, 8);
        chk(fok, 1'b1);
        t_start(3'h7, 150, 176);
        give_verdict();
    end
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule : test_serializer_link_control_regs
